// ---- ocd_cfg_if.sv ----
`timescale 1ns/100ps
`include "ocd_defs.svh"

interface ocd_cfg_if;
    logic [`OCD_CNT_W-1:0] low_cnt;
    logic [`OCD_CNT_W-1:0] high_cnt;
    logic [`OCD_CNT_W-1:0] phase;
    logic bypass;
    logic ignore_align;
    logic force_out;
    logic start_high;
    logic align;
    logic level;

    modport ctrl (
        output low_cnt, high_cnt, phase, bypass, ignore_align, force_out, start_high, align,
        input level
    );
    modport div (
        input low_cnt, high_cnt, phase, bypass, ignore_align, force_out, start_high, align,
        output level
    );
endinterface : ocd_cfg_if

// ---- ocd_defs.svh ----
`ifndef OCD_DEFS_SVH
`define OCD_DEFS_SVH

// ----------------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------------
`define OCD_ADDR_W 10
`define OCD_ADDR_DIV0_COUNTS 10'h190
`define OCD_ADDR_DIV0_MODE 10'h191
`define OCD_ADDR_CH0_CTRL 10'h192
`define OCD_ADDR_DIV1_COUNTS 10'h193
`define OCD_ADDR_DIV1_MODE 10'h194
`define OCD_ADDR_CH1_CTRL 10'h195

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define OCD_RST_DIV0_COUNTS 8'h77
`define OCD_RST_DIV1_COUNTS 8'h33
`define OCD_RST_MODE 8'h00
`define OCD_RST_CTRL 3'h0

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define OCD_CNT_W 4
`define OCD_LOW_HI 7
`define OCD_LOW_LO 4
`define OCD_HIGH_HI 3
`define OCD_HIGH_LO 0
`define OCD_BIT_BYPASS 7
`define OCD_BIT_IGNORE_ALIGN 6
`define OCD_BIT_FORCE 5
`define OCD_BIT_START_HIGH 4
`define OCD_PHASE_HI 3
`define OCD_PHASE_LO 0
`define OCD_BIT_POWER_DOWN 2
`define OCD_BIT_DIRECT 1
`define OCD_BIT_DCC_OFF 0
`define OCD_CTRL_W 3

// ----------------------------------------------------------------------------
// Source select codes
// ----------------------------------------------------------------------------
`define OCD_SRC_OSC 2'h2
`define OCD_SRC_EXT 2'h0

`endif

// ---- ocd_divider.sv ----
`timescale 1ns/100ps
`include "ocd_defs.svh"

module ocd_divider #(
    parameter int CNT_W = 4
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    ocd_cfg_if.div cfg
);
    import ocd_pkg::*;

    ocd_div_state_t st;
    ocd_div_state_t next_st;

    generate
        if (CNT_W != `OCD_CNT_W) begin : g_bad_width
            $error("ocd_divider: CNT_W must match the register field width");
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Half-period counter
    // ------------------------------------------------------------------------
    always_comb begin
        next_st = st;
        if (cfg.bypass) begin
            // Counter is stopped while bypassed, standing in for power-down.
            next_st.mode = OCD_BYPASS;
            next_st.level = 1'b0;
            next_st.cnt = '0;
        end else if (cfg.force_out) begin
            next_st.mode = OCD_FORCED;
            next_st.level = cfg.start_high;
        end else if (cfg.align && !cfg.ignore_align) begin
            next_st.mode = OCD_DELAY;
            next_st.level = cfg.start_high;
            next_st.cnt = cfg.phase;
        end else begin
            case (st.mode)
                OCD_RUN: begin
                    if (st.cnt == '0) begin
                        next_st.level = ~st.level;
                        next_st.cnt = st.level ? cfg.low_cnt : cfg.high_cnt;
                    end else begin
                        next_st.cnt = st.cnt - 1'b1;
                    end
                end
                OCD_DELAY: begin
                    if (st.cnt == '0) begin
                        next_st.mode = OCD_RUN;
                        next_st.cnt = st.level ? cfg.high_cnt : cfg.low_cnt;
                    end else begin
                        next_st.cnt = st.cnt - 1'b1;
                    end
                end
                default: begin
                    // Leaving a static state restarts cleanly at the start level.
                    next_st.mode = OCD_DELAY;
                    next_st.level = cfg.start_high;
                    next_st.cnt = cfg.phase;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            next_st_reset: st <= '{mode: OCD_DELAY, level: 1'b0, cnt: '0};
        end else begin
            st <= next_st;
        end
    end

    assign cfg.level = st.level;

endmodule : ocd_divider

// ---- ocd_pkg.sv ----
`include "ocd_defs.svh"

package ocd_pkg;

    typedef enum logic [1:0] {
        OCD_RUN = 2'b00,
        OCD_DELAY = 2'b01,
        OCD_FORCED = 2'b10,
        OCD_BYPASS = 2'b11
    } ocd_mode_t;

    typedef struct packed {
        ocd_mode_t mode;
        logic level;
        logic [`OCD_CNT_W-1:0] cnt;
    } ocd_div_state_t;

    typedef struct packed {
        logic [1:0][7:0] counts;
        logic [1:0][7:0] mode;
        logic [1:0][`OCD_CTRL_W-1:0] ctrl;
        logic [7:0] rdata;
        logic [1:0][2:0] grp;
        logic [1:0] dcc;
    } ocd_top_state_t;

endpackage : ocd_pkg

// ---- ocd_sink.sv ----
`timescale 1ns/100ps

module ocd_sink (
    input wire logic clk_i,
    input wire logic level_i,
    output logic [5:0] high_len_o,
    output logic [5:0] low_len_o
);
    // ------------------------------------------------------------------
    // Run length meter
    // ------------------------------------------------------------------
    // A length is only trusted after a whole run between two changes.
    logic [5:0] run = 6'h0;
    logic last = 1'b0;
    always @(posedge clk_i) begin
        last <= level_i;
        if (level_i != last) begin
            run <= 6'h1;
            if (last) begin
                high_len_o <= run;
            end else begin
                low_len_o <= run;
            end
        end else begin
            run <= run + 6'h1;
        end
    end
endmodule : ocd_sink

// ---- ocd_top.sv ----
`timescale 1ns/100ps
`include "ocd_defs.svh"

// Summary of operation
// - Output stays low for low-count field plus one input cycles.
// - Output stays high for high-count field plus one input cycles.
// - Second divider counts reset to three, four cycles low and high.
// - Bypass bit stops the divider and passes its input straight out.
// - Alignment pulse restarts the divider unless ignore-alignment is set.
// - Force bit holds output at start level; otherwise it runs normally.
// - Force has no effect when bypassed; polarity reversal still applies.
// - Start-level bit picks whether the output begins low or high.
// - Each divider has a four-bit phase offset resetting to zero.
// - Channel power-down puts all three group outputs in safe low state.
// - Direct bit with source select 10b routes oscillator to the group.
// - Direct bit with source select 00b routes external clock to group.
// - Source select 01b or direct bit clear keeps divider feeding outputs.
// - Duty-cycle correction is on by default, off when disable bit set.
// - First divider counts reset to seven, eight cycles low and high.

module ocd_top (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [`OCD_ADDR_W-1:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    input wire logic align_i,
    input wire logic [1:0] source_sel_i,
    input wire logic div_in_i,
    input wire logic internal_oscillator_i,
    input wire logic ext_clk_i,
    input wire logic [1:0] pol_invert_i,
    output logic group0_output_a_o,
    output logic group0_output_b_o,
    output logic group0_output_c_o,
    output logic group1_output_a_o,
    output logic group1_output_b_o,
    output logic group1_output_c_o,
    output logic [1:0] duty_cycle_correction_o
);
    import ocd_pkg::*;

    localparam int NUM_CH = 2;

    ocd_top_state_t st;
    ocd_top_state_t next_st;
    logic [NUM_CH-1:0] div_level;
    logic [NUM_CH-1:0] ch_bypass;
    logic [NUM_CH-1:0] ch_direct;
    logic [NUM_CH-1:0] ch_power_down;
    logic [NUM_CH-1:0] ch_dcc_off;

    // ------------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------------
    // Both count fields and the phase field must fit the divider's counter.
    generate
        if (`OCD_LOW_HI - `OCD_LOW_LO + 1 != `OCD_CNT_W || `OCD_HIGH_HI - `OCD_HIGH_LO + 1 != `OCD_CNT_W
            || `OCD_PHASE_HI - `OCD_PHASE_LO + 1 != `OCD_CNT_W) begin : g_bad_fields
            $error("ocd_top: count and phase fields must match the counter width");
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Channel dividers
    // ------------------------------------------------------------------------
    generate
        for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
            ocd_cfg_if u_cfg ();

            assign u_cfg.low_cnt = st.counts[g][`OCD_LOW_HI:`OCD_LOW_LO];
            assign u_cfg.high_cnt = st.counts[g][`OCD_HIGH_HI:`OCD_HIGH_LO];
            assign u_cfg.phase = st.mode[g][`OCD_PHASE_HI:`OCD_PHASE_LO];
            assign u_cfg.bypass = st.mode[g][`OCD_BIT_BYPASS];
            assign u_cfg.ignore_align = st.mode[g][`OCD_BIT_IGNORE_ALIGN];
            assign u_cfg.force_out = st.mode[g][`OCD_BIT_FORCE];
            assign u_cfg.start_high = st.mode[g][`OCD_BIT_START_HIGH];
            assign u_cfg.align = align_i;
            assign div_level[g] = u_cfg.level;

            // Control fields are decoded once per channel, next to its divider.
            assign ch_bypass[g] = st.mode[g][`OCD_BIT_BYPASS];
            assign ch_direct[g] = st.ctrl[g][`OCD_BIT_DIRECT];
            assign ch_power_down[g] = st.ctrl[g][`OCD_BIT_POWER_DOWN];
            assign ch_dcc_off[g] = st.ctrl[g][`OCD_BIT_DCC_OFF];

            ocd_divider #(
                .CNT_W(`OCD_CNT_W)
            ) u_div (
                .clk_i(clk_i),
                .resetn_i(resetn_i),
                .cfg(u_cfg)
            );
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Register file and output routing
    // ------------------------------------------------------------------------
    always_comb begin
        logic ch_level;
        logic direct;
        ch_level = 1'b0;
        direct = 1'b0;
        next_st = st;

        // --------------------------------------------------------------------
        // Register writes
        // --------------------------------------------------------------------
        if (reg_wr_i) begin
            case (reg_addr_i)
                `OCD_ADDR_DIV0_COUNTS: begin
                    next_st.counts[0] = reg_wdata_i;
                end
                `OCD_ADDR_DIV0_MODE: begin
                    next_st.mode[0] = reg_wdata_i;
                end
                `OCD_ADDR_CH0_CTRL: begin
                    next_st.ctrl[0] = reg_wdata_i[`OCD_CTRL_W-1:0];
                end
                `OCD_ADDR_DIV1_COUNTS: begin
                    next_st.counts[1] = reg_wdata_i;
                end
                `OCD_ADDR_DIV1_MODE: begin
                    next_st.mode[1] = reg_wdata_i;
                end
                `OCD_ADDR_CH1_CTRL: begin
                    next_st.ctrl[1] = reg_wdata_i[`OCD_CTRL_W-1:0];
                end
                default: begin
                    next_st.rdata = st.rdata;
                end
            endcase
        end

        // --------------------------------------------------------------------
        // Register reads
        // --------------------------------------------------------------------
        // Unmapped addresses read back as zero, as do the unused control bits.
        if (reg_rd_i) begin
            case (reg_addr_i)
                `OCD_ADDR_DIV0_COUNTS: begin
                    next_st.rdata = st.counts[0];
                end
                `OCD_ADDR_DIV0_MODE: begin
                    next_st.rdata = st.mode[0];
                end
                `OCD_ADDR_CH0_CTRL: begin
                    next_st.rdata = {5'h00, st.ctrl[0]};
                end
                `OCD_ADDR_DIV1_COUNTS: begin
                    next_st.rdata = st.counts[1];
                end
                `OCD_ADDR_DIV1_MODE: begin
                    next_st.rdata = st.mode[1];
                end
                `OCD_ADDR_CH1_CTRL: begin
                    next_st.rdata = {5'h00, st.ctrl[1]};
                end
                default: begin
                    next_st.rdata = 8'h00;
                end
            endcase
        end

        // --------------------------------------------------------------------
        // Output routing
        // --------------------------------------------------------------------
        for (int c = 0; c < NUM_CH; c++) begin
            direct = ch_direct[c];
            if (direct && source_sel_i == `OCD_SRC_OSC) begin
                ch_level = internal_oscillator_i;
            end else if (direct && source_sel_i == `OCD_SRC_EXT) begin
                ch_level = ext_clk_i;
            end else if (ch_bypass[c]) begin
                ch_level = div_in_i;
            end else begin
                ch_level = div_level[c];
            end
            // Inversion stands in for the driver polarity, kept even in bypass.
            ch_level = ch_level ^ pol_invert_i[c];
            if (ch_power_down[c]) begin
                next_st.grp[c] = 3'h0;
            end else begin
                next_st.grp[c] = {3{ch_level}};
            end
            // Correction is reported unless its disable bit or the bypass bit is set.
            next_st.dcc[c] = ~ch_dcc_off[c] & ~ch_bypass[c];
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st.counts[0] <= `OCD_RST_DIV0_COUNTS;
            st.counts[1] <= `OCD_RST_DIV1_COUNTS;
            st.mode[0] <= `OCD_RST_MODE;
            st.mode[1] <= `OCD_RST_MODE;
            st.ctrl[0] <= `OCD_RST_CTRL;
            st.ctrl[1] <= `OCD_RST_CTRL;
            st.rdata <= 8'h00;
            st.grp <= '0;
            st.dcc <= 2'h0;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign reg_rdata_o = st.rdata;
    assign group0_output_a_o = st.grp[0][0];
    assign group0_output_b_o = st.grp[0][1];
    assign group0_output_c_o = st.grp[0][2];
    assign group1_output_a_o = st.grp[1][0];
    assign group1_output_b_o = st.grp[1][1];
    assign group1_output_c_o = st.grp[1][2];
    assign duty_cycle_correction_o = st.dcc;

endmodule : ocd_top

// ---- ocd_top_monitor.sv ----
`timescale 1ns/100ps
`include "ocd_defs.svh"

module ocd_top_monitor (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [`OCD_ADDR_W-1:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic [1:0] source_sel_i,
    input wire logic div_in_i,
    input wire logic internal_oscillator_i,
    input wire logic [1:0] pol_invert_i,
    input wire logic group1_output_a_o,
    input wire logic group1_output_b_o,
    input wire logic group1_output_c_o,
    input wire logic [1:0] duty_cycle_correction_o
);
    // ------------------------------------------------------------------
    // Shadow registers of channel 1
    // ------------------------------------------------------------------
    logic [7:0] mode1;
    logic [2:0] ctrl1;
    logic run1;
    logic frc1;
    logic group0_output_b;
    // Source select 01b leaves the divider in charge even with the direct bit set.
    assign run1 = !ctrl1[2] && !(ctrl1[1] && source_sel_i != 2'h1);
    assign frc1 = run1 && !mode1[7] && mode1[5];
    assign group0_output_b = group1_output_a_o;
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            mode1 <= 8'h00;
            ctrl1 <= 3'h0;
        end else if (reg_wr_i && reg_addr_i == `OCD_ADDR_DIV1_MODE) begin
            mode1 <= reg_wdata_i;
        end else if (reg_wr_i && reg_addr_i == `OCD_ADDR_CH1_CTRL) begin
            ctrl1 <= reg_wdata_i[2:0];
        end
    end
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);
    property p_same; group1_output_b_o == group0_output_b && group1_output_c_o == group0_output_b; endproperty
    a_same: assert property (p_same) else $error("group outputs differ");
    property p_pd; ctrl1[2] |=> !group0_output_b && !group1_output_c_o; endproperty
    a_pd: assert property (p_pd) else $error("powered down group drives");
    property p_byp; run1 && mode1[7] |=> group0_output_b == $past(div_in_i ^ pol_invert_i[1]); endproperty
    a_byp: assert property (p_byp) else $error("bypass path wrong");
    property p_frc; frc1 ##1 frc1 |=> group0_output_b == ($past(mode1[4], 2) ^ $past(pol_invert_i[1])); endproperty
    a_frc: assert property (p_frc) else $error("forced level wrong");
    property p_osc;
        !ctrl1[2] && ctrl1[1] && source_sel_i == 2'h2 && !pol_invert_i[1] |=> group0_output_b == $past(internal_oscillator_i);
    endproperty
    a_osc: assert property (p_osc) else $error("oscillator route wrong");
    property p_dcc; 1'b1 |=> duty_cycle_correction_o[1] == $past(!ctrl1[0] && !mode1[7]); endproperty
    a_dcc: assert property (p_dcc) else $error("correction status wrong");
    property p_mrd; reg_rd_i && reg_addr_i == `OCD_ADDR_DIV1_MODE |=> reg_rdata_o == $past(mode1); endproperty
    a_mrd: assert property (p_mrd) else $error("mode readback wrong");
    property p_crd; reg_rd_i && reg_addr_i == `OCD_ADDR_CH1_CTRL |=> reg_rdata_o == {5'h0, $past(ctrl1)}; endproperty
    a_crd: assert property (p_crd) else $error("control readback wrong");
    cover property (frc1 ##1 frc1);
    cover property (run1 && mode1[7]);
    cover property (ctrl1[2]);
endmodule : ocd_top_monitor

bind ocd_top ocd_top_monitor u_ocd_top_monitor (
    .clk_i, .resetn_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .source_sel_i,
    .div_in_i, .internal_oscillator_i, .pol_invert_i, .group1_output_a_o, .group1_output_b_o,
    .group1_output_c_o, .duty_cycle_correction_o
);

// ---- tb_output_channel_divider.sv ----
`timescale 1ns/100ps
`include "ocd_defs.svh"

module tb_output_channel_divider;
    logic clk_i = 1'b0, resetn_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0, align_i = 1'b0;
    logic div_in_i = 1'b0, internal_oscillator_i = 1'b0, ext_clk_i = 1'b0, snap;
    logic [`OCD_ADDR_W-1:0] reg_addr_i = '0;
    logic [7:0] reg_wdata_i = 8'h00, reg_rdata_o;
    logic [1:0] source_sel_i = 2'h1, pol_invert_i = 2'h0, duty_cycle_correction_o;
    logic group0_output_a_o, group0_output_b_o, group0_output_c_o;
    logic group1_output_a_o, group1_output_b_o, group1_output_c_o;
    logic [5:0] hi0, lo0, hi1, lo1;
    wire [2:0] g1 = {group1_output_c_o, group1_output_b_o, group1_output_a_o};
    wire [2:0] g0 = {group0_output_c_o, group0_output_b_o, group0_output_a_o};
    int fails = 0, cmp_count = 0, n, n0, n5;

    initial begin
        forever #25 clk_i = ~clk_i;
    end

    ocd_top u_ocd_top (.clk_i, .resetn_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o,
        .align_i, .source_sel_i, .div_in_i, .internal_oscillator_i, .ext_clk_i, .pol_invert_i,
        .group0_output_a_o, .group0_output_b_o, .group0_output_c_o, .group1_output_a_o,
        .group1_output_b_o, .group1_output_c_o, .duty_cycle_correction_o);
    ocd_sink u_ocd_sink (.clk_i, .level_i(group1_output_a_o), .high_len_o(hi1), .low_len_o(lo1));
    ocd_sink u_ocd_sink_g0 (.clk_i, .level_i(group0_output_a_o), .high_len_o(hi0), .low_len_o(lo0));

    task automatic tick;
        @(posedge clk_i);
        #1;
    endtask : tick

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic results;
        if (fails == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : results

    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        reg_wr_i = 1'b1;
        reg_addr_i = a;
        reg_wdata_i = d;
        tick;
        reg_wr_i = 1'b0;
        tick;
    endtask : wr

    task automatic rd(input logic [9:0] a, input logic [7:0] e);
        reg_rd_i = 1'b1;
        reg_addr_i = a;
        tick;
        reg_rd_i = 1'b0;
        check(reg_rdata_o, e);
        tick;
    endtask : rd

    task automatic chk_g1(input logic [7:0] e);
        repeat (2) tick;
        check(8'(g1), e);
    endtask : chk_g1

    task automatic wait_g1(input logic v, output int k);
        for (k = 0; g1[0] !== v; k++) begin
            if (k > 99) begin
                fails++;
                results;
            end
            tick;
        end
    endtask : wait_g1

    // Three edges pass before the level is read, so a restart has surely landed.
    task automatic lat(output int k);
        align_i = 1'b1;
        tick;
        align_i = 1'b0;
        repeat (2) tick;
        snap = g1[0];
        wait_g1(1'b1, k);
    endtask : lat

    initial begin
        repeat (2) @(posedge clk_i);
        #1;
        resetn_i = 1'b1;
        rd(`OCD_ADDR_DIV0_COUNTS, 8'h77);
        rd(`OCD_ADDR_DIV1_COUNTS, 8'h33);
        rd(`OCD_ADDR_DIV1_MODE, 8'h00);
        rd(`OCD_ADDR_CH0_CTRL, 8'h00);
        rd(10'h1ff, 8'h00);
        repeat (50) tick;
        check(8'(hi0), 8'h08);
        check(8'(lo0), 8'h08);
        check(8'(hi1), 8'h04);
        check(8'(lo1), 8'h04);
        check(8'(duty_cycle_correction_o), 8'h03);
        wr(`OCD_ADDR_DIV1_COUNTS, 8'h21);
        repeat (20) tick;
        check(8'(hi1), 8'h02);
        check(8'(lo1), 8'h03);
        wr(`OCD_ADDR_DIV1_COUNTS, 8'h00);
        repeat (8) tick;
        check(8'(hi1 + lo1), 8'h02);
        wr(`OCD_ADDR_DIV1_COUNTS, 8'h33);
        for (int i = 0; i < 2; i++) begin
            wr(`OCD_ADDR_DIV1_MODE, 8'(i * 64));
            wait_g1(1'b0, n);
            wait_g1(1'b1, n);
            lat(n);
            check(8'(snap), 8'(i));
        end
        wr(`OCD_ADDR_DIV1_MODE, 8'h00);
        lat(n0);
        wr(`OCD_ADDR_DIV1_MODE, 8'h05);
        lat(n5);
        check(8'(n5 - n0), 8'h05);
        wr(`OCD_ADDR_DIV1_MODE, 8'h70);
        chk_g1(8'h07);
        wr(`OCD_ADDR_DIV1_MODE, 8'h60);
        chk_g1(8'h00);
        div_in_i = 1'b1;
        wr(`OCD_ADDR_DIV1_MODE, 8'ha0);
        chk_g1(8'h07);
        pol_invert_i = 2'h2;
        chk_g1(8'h00);
        check(8'(duty_cycle_correction_o), 8'h01);
        pol_invert_i = 2'h0;
        wr(`OCD_ADDR_CH1_CTRL, 8'hff);
        chk_g1(8'h00);
        rd(`OCD_ADDR_CH1_CTRL, 8'h07);
        div_in_i = 1'b0;
        internal_oscillator_i = 1'b1;
        source_sel_i = 2'h2;
        wr(`OCD_ADDR_CH1_CTRL, 8'h02);
        chk_g1(8'h07);
        internal_oscillator_i = 1'b0;
        ext_clk_i = 1'b1;
        source_sel_i = 2'h0;
        chk_g1(8'h07);
        source_sel_i = 2'h1;
        chk_g1(8'h00);
        wr(`OCD_ADDR_CH1_CTRL, 8'h01);
        wr(`OCD_ADDR_DIV1_MODE, 8'h00);
        tick;
        check(8'(duty_cycle_correction_o), 8'h01);
        source_sel_i = 2'h0;
        wr(`OCD_ADDR_CH0_CTRL, 8'h02);
        repeat (2) tick;
        check(8'(g0), 8'h07);
        wr(`OCD_ADDR_CH0_CTRL, 8'h06);
        repeat (2) tick;
        check(8'(g0), 8'h00);
        rd(`OCD_ADDR_CH0_CTRL, 8'h06);
        results;
    end
endmodule : tb_output_channel_divider
